// File: core/hpd_core.sv
// Bridge protection, current chopper and diagnosis logic with a Wishbone slave.
// Assumes all comparator and pin inputs are synchronous to clk_i.
`timescale 1ns/10ps
// Summary of operation
// - High-side overcurrent past blanking forces the opposite leg high.
// - Current below limit minus hysteresis returns forced leg to following inputs.
// - Two control bits select one of four current limits.
// - Chopper transitions are spaced by a least interval.
// - Chopping acts only in bridge mode, never in single-switch mode.
// - Between reduction start and shutdown temperature the limit is reduced.
// - High-side current above short threshold for filter time flags ground short.
// - A shorted leg is switched off at once.
// - In bridge mode the other leg follows off after a short delay.
// - In single-switch mode only the shorted leg switches off.
// - Battery shorts use the same filter, watching low-side current.
// - A short across the load sets both bits and stops both legs.
// - Overtemperature turns every output switch off.
// - Supply undervoltage stops outputs until supply recovers above on threshold.
// - In flag mode faults pull the fault flag pin low.
// - Fault flag is not pulled low below logic power-on threshold.
// - Open-load sources run only while disabled by inputs, not after shorts.
// - Open-load sources stay off in status flag mode.
// - Bridge open load means leg A below and leg B above reference.
// - Single-switch open load means both leg comparators read low.
// - Each fault is evaluated only in the switch state that shows it.
// - Enable or disable changes complete within 20 or 75 microseconds.
module hpd_core #(
    parameter logic [15:0] TRANS_CYC_P     = 16'(hpd_pkg::TRANS_CYC),
    parameter logic [15:0] DDIS_SLOW_CYC_P = 16'(hpd_pkg::DDIS_SLOW_CYC)
) (
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    input  wire logic                       cyc_i,
    input  wire logic                       stb_i,
    input  wire logic                       we_i,
    input  wire logic [hpd_pkg::ADDR_W-1:0] adr_i,
    input  wire logic [3:0]                 sel_i,
    input  wire logic [31:0]                dat_i,
    output logic      [31:0]                dat_o,
    output logic                            ack_o,
    input  wire logic                       input_one_i,
    input  wire logic                       input_two_i,
    input  wire logic                       bridge_enable_n_i,
    input  wire logic                       bridge_off_pin_i,
    input  wire logic                       io_supply_pin_i,
    input  wire logic                       upper_over_lim_a_i,
    input  wire logic                       upper_over_lim_b_i,
    input  wire logic                       upper_below_hys_a_i,
    input  wire logic                       upper_below_hys_b_i,
    input  wire logic                       upper_short_a_i,
    input  wire logic                       upper_short_b_i,
    input  wire logic                       lower_short_a_i,
    input  wire logic                       lower_short_b_i,
    input  wire logic                       temp_reduce_i,
    input  wire logic                       temp_shutdown_i,
    input  wire logic                       vs_below_off_i,
    input  wire logic                       vs_above_on_i,
    input  wire logic                       vdd_mon_fault_i,
    input  wire logic                       vdd_below_por_i,
    input  wire logic                       leg_a_low_cmp_i,
    input  wire logic                       leg_b_low_cmp_i,
    input  wire logic                       leg_a_high_cmp_i,
    input  wire logic                       leg_b_high_cmp_i,
    output logic                            upper_switch_a_o,
    output logic                            lower_switch_a_o,
    output logic                            upper_switch_b_o,
    output logic                            lower_switch_b_o,
    output logic [1:0]                      limit_sel_o,
    output logic                            limit_reduce_o,
    output logic                            diag_src_en_o,
    output logic                            fault_flag_pin_o,
    output logic                            fault_flag_pin_oe_o
);
    import hpd_pkg::*;

    // Control register
    logic              single_r;
    logic [1:0]        cl_r;
    logic              slow_r;
    // Fault state
    logic [1:0]        scg_r;
    logic [1:0]        scb_r;
    logic [1:0]        ol_r;
    logic              uv_r;
    logic              peer_off_r;
    logic [CNT_W-1:0]  dly_cnt_r;
    // Enable delay
    logic              en_eff_r;
    logic [CNT_W-1:0]  en_cnt_r;
    // Chopper per leg
    hpd_chop_t         chop_st_r [2];
    hpd_chop_t         chop_nxt  [2];
    logic [CNT_W-1:0]  blank_cnt_r [2];
    logic [CNT_W-1:0]  gap_cnt_r [2];
    logic [1:0]        gap_done;

    // Leg vectors
    wire [1:0] leg_in    = {input_two_i, input_one_i};
    wire [1:0] over_lim  = {upper_over_lim_b_i, upper_over_lim_a_i};
    wire [1:0] below_hys = {upper_below_hys_b_i, upper_below_hys_a_i};
    wire [1:0] up_short  = {upper_short_b_i, upper_short_a_i};
    wire [1:0] lo_short  = {lower_short_b_i, lower_short_a_i};
    wire [1:0] up_on     = {upper_switch_b_o, upper_switch_a_o};
    wire [1:0] lo_on     = {lower_switch_b_o, lower_switch_a_o};
    logic [1:0] scg_hit;
    logic [1:0] scb_hit;

    // Bus decode
    wire        wb_req    = cyc_i & stb_i & !ack_o;
    wire        wb_wr     = wb_req & we_i & sel_i[0];
    wire        hit_ctrl  = (adr_i == REG_CTRL);
    wire        hit_stat  = (adr_i == REG_STAT);
    wire        hit_fault = (adr_i == REG_FAULT);
    wire [3:0]  fault_clr = (wb_wr && hit_fault) ? dat_i[3:0] : 4'h0;

    // Shutdown causes
    wire        en_req    = !bridge_enable_n_i & !bridge_off_pin_i;
    wire        any_short = |{scg_r, scb_r};
    wire        across    = (scg_r[0] & scb_r[1]) | (scg_r[1] & scb_r[0]);
    wire [1:0]  own_short = scg_r | scb_r;
    wire        global_ok = en_eff_r & !uv_r & !temp_shutdown_i & !vdd_mon_fault_i;
    logic [1:0] leg_run;
    logic [1:0] forced_hi;
    logic [1:0] drive_hi;

    // single mode stops only own leg; across-load stops both
    assign leg_run[0] = global_ok & !own_short[0] & !across & !(!single_r & peer_off_r);
    assign leg_run[1] = global_ok & !own_short[1] & !across & !(!single_r & peer_off_r);
    // forcing from the opposite leg's chopper
    assign forced_hi  = {chop_st_r[0] == CHP_FORCE, chop_st_r[1] == CHP_FORCE};
    assign drive_hi   = forced_hi | leg_in;

    // Enable delay bound per slew rate
    wire [CNT_W-1:0] en_dly  = slow_r ? DDIS_SLOW_CYC_P : CNT_W'(DDIS_FAST_CYC);
    wire             en_done = (en_cnt_r >= en_dly - CNT_W'(2));

    // Fault flag and diagnosis sources
    wire flag_mode = !io_supply_pin_i;
    wire flag_cond = uv_r | !en_req | vdd_mon_fault_i | any_short | temp_shutdown_i;
    wire diag_on   = !en_req & !en_eff_r & !any_short & !flag_mode;
    wire [1:0] ol_single = {!leg_b_high_cmp_i & !leg_b_low_cmp_i,
                            !leg_a_high_cmp_i & !leg_a_low_cmp_i};
    wire       ol_bridge = !leg_a_low_cmp_i & leg_b_low_cmp_i;
    wire [1:0] ol_nxt    = !diag_on ? 2'h0 : (single_r ? ol_single : {1'b0, ol_bridge});

    // Read mux
    wire [31:0] stat_word = 32'({limit_reduce_o, en_eff_r,
                                 fault_flag_pin_oe_o, forced_hi[1], forced_hi[0], ol_r,
                                 uv_r, temp_shutdown_i, scb_r, scg_r});
    wire [31:0] ctrl_word = 32'({slow_r, cl_r, single_r});
    wire [31:0] rd_word   = hit_ctrl  ? ctrl_word :
                            hit_stat  ? stat_word :
                            hit_fault ? 32'({scb_r, scg_r}) : 32'h0000_0000;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_leg
            // ground short watched while upper switch conducts
            // battery short watched while lower switch conducts
            hpd_short_filter #(.FILT(FILT_CYC)) u_scg (
                .clk_i  (clk_i),
                .rst_i  (rst_i),
                .arm_i  (up_on[g]),
                .over_i (up_short[g]),
                .hit_o  (scg_hit[g])
            );
            hpd_short_filter #(.FILT(FILT_CYC)) u_scb (
                .clk_i  (clk_i),
                .rst_i  (rst_i),
                .arm_i  (lo_on[g]),
                .over_i (lo_short[g]),
                .hit_o  (scb_hit[g])
            );

            assign gap_done[g] = (gap_cnt_r[g] >= TRANS_CYC_P);

            always_comb begin
                chop_nxt[g] = chop_st_r[g];
                unique case (chop_st_r[g])
                    CHP_IDLE: begin
                        if (over_lim[g] && up_on[g]) begin
                            chop_nxt[g] = CHP_BLANK;
                        end
                    end
                    CHP_BLANK: begin
                        if (!over_lim[g]) begin
                            chop_nxt[g] = CHP_IDLE;
                        end else if (blank_cnt_r[g] >= CNT_W'(BLANK_CYC) && gap_done[g]) begin
                            chop_nxt[g] = CHP_FORCE;
                        end
                    end
                    CHP_FORCE: begin
                        if (below_hys[g] && gap_done[g]) begin
                            chop_nxt[g] = CHP_IDLE;
                        end
                    end
                    default: chop_nxt[g] = CHP_IDLE;
                endcase
                if (single_r) begin
                    chop_nxt[g] = CHP_IDLE;
                end
            end

            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    chop_st_r[g]   <= CHP_IDLE;
                    blank_cnt_r[g] <= '0;
                    gap_cnt_r[g]   <= TRANS_CYC_P;
                end else begin
                    chop_st_r[g]   <= chop_nxt[g];
                    blank_cnt_r[g] <= (chop_st_r[g] == CHP_BLANK) ?
                                      blank_cnt_r[g] + CNT_W'(1) : '0;
                    if ((chop_nxt[g] == CHP_FORCE) != (chop_st_r[g] == CHP_FORCE)) begin
                        gap_cnt_r[g] <= '0;
                    end else if (!gap_done[g]) begin
                        gap_cnt_r[g] <= gap_cnt_r[g] + CNT_W'(1);
                    end
                end
            end
        end
    endgenerate

    // Register interface
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o    <= 1'b0;
            dat_o    <= 32'h0000_0000;
            single_r <= 1'b0;
            cl_r     <= CL_RST;
            slow_r   <= 1'b0;
        end else begin
            ack_o <= wb_req;
            dat_o <= wb_req ? rd_word : 32'h0000_0000;
            if (wb_wr && hit_ctrl) begin
                single_r <= dat_i[CTRL_SINGLE];
                cl_r     <= dat_i[CTRL_CL_HI:CTRL_CL_LO];
                slow_r   <= dat_i[CTRL_SLOW];
            end
        end
    end

    // Short latches and peer switch-off
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scg_r      <= 2'h0;
            scb_r      <= 2'h0;
            peer_off_r <= 1'b0;
            dly_cnt_r  <= '0;
        end else begin
            scg_r <= scg_hit | (scg_r & ~fault_clr[1:0]);
            scb_r <= scb_hit | (scb_r & ~fault_clr[3:2]);
            if (!any_short) begin
                dly_cnt_r  <= '0;
                peer_off_r <= 1'b0;
            end else if (dly_cnt_r < CNT_W'(DEL_CYC - 1)) begin
                dly_cnt_r <= dly_cnt_r + CNT_W'(1);
            end else begin
                peer_off_r <= 1'b1;
            end
        end
    end

    // Undervoltage hysteresis, enable delay, diagnosis
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            uv_r     <= 1'b0;
            en_eff_r <= 1'b0;
            en_cnt_r <= '0;
            ol_r     <= 2'h0;
        end else begin
            // off below off threshold, back above on threshold
            if (vs_below_off_i) begin
                uv_r <= 1'b1;
            end else if (vs_above_on_i) begin
                uv_r <= 1'b0;
            end
            if (en_req == en_eff_r) begin
                en_cnt_r <= '0;
            end else if (en_done) begin
                en_eff_r <= en_req;
                en_cnt_r <= '0;
            end else begin
                en_cnt_r <= en_cnt_r + CNT_W'(1);
            end
            // bridge decode; single decode; only when inactive
            ol_r <= ol_nxt;
        end
    end

    // Output stage and pins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            upper_switch_a_o    <= 1'b0;
            lower_switch_a_o    <= 1'b0;
            upper_switch_b_o    <= 1'b0;
            lower_switch_b_o    <= 1'b0;
            limit_sel_o         <= CL_RST;
            limit_reduce_o      <= 1'b0;
            diag_src_en_o       <= 1'b0;
            fault_flag_pin_o    <= 1'b0;
            fault_flag_pin_oe_o <= 1'b0;
        end else begin
            // every switch off on overtemperature via leg_run
            upper_switch_a_o    <= leg_run[0] & drive_hi[0];
            lower_switch_a_o    <= leg_run[0] & !drive_hi[0];
            upper_switch_b_o    <= leg_run[1] & drive_hi[1];
            lower_switch_b_o    <= leg_run[1] & !drive_hi[1];
            limit_sel_o         <= cl_r;
            // limit reduction in the warm band
            limit_reduce_o      <= temp_reduce_i & !temp_shutdown_i;
            // sources only while disabled by inputs
            diag_src_en_o       <= diag_on;
            fault_flag_pin_o    <= 1'b0;
            fault_flag_pin_oe_o <= flag_mode & flag_cond & !vdd_below_por_i;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence seq_hit_a;
        scg_hit[0] ##1 scg_r[0];
    endsequence
    sequence seq_peer_wait;
        (any_short && !peer_off_r) [*8];
    endsequence

    chk_single_nochop: assert property (
        single_r && $past(single_r) |-> chop_st_r[0] == CHP_IDLE && chop_st_r[1] == CHP_IDLE)
        else $error("chopper active in single mode");
    chk_force_opposite: assert property (
        chop_st_r[0] == CHP_FORCE && leg_run[1] |=> upper_switch_b_o && !lower_switch_b_o)
        else $error("opposite leg not forced high");
    chk_chop_release: assert property (
        chop_st_r[0] == CHP_FORCE && below_hys[0] && gap_done[0] && !single_r
        |=> chop_st_r[0] == CHP_IDLE)
        else $error("chopper did not release");
    chk_trans_spacing: assert property (
        chop_st_r[0] == CHP_FORCE && !gap_done[0] |=> chop_st_r[0] == CHP_FORCE)
        else $error("chopper transition too early");
    chk_short_leg_off: assert property (
        seq_hit_a |=> !upper_switch_a_o && !lower_switch_a_o)
        else $error("shorted leg still on");
    chk_peer_leg_off: assert property (
        peer_off_r && !single_r |=> !upper_switch_b_o && !lower_switch_b_o)
        else $error("peer leg not switched off");
    chk_peer_delay: assert property (
        $rose(any_short) |-> !peer_off_r ##1 seq_peer_wait)
        else $error("peer delay violated");
    chk_ot_all_off: assert property (
        temp_shutdown_i |=> !upper_switch_a_o && !lower_switch_a_o
                            && !upper_switch_b_o && !lower_switch_b_o)
        else $error("switch on during overtemperature");
    chk_uv_hold: assert property (
        uv_r && !vs_above_on_i |=> uv_r)
        else $error("undervoltage released early");
    chk_flag_por: assert property (
        vdd_below_por_i |=> !fault_flag_pin_oe_o)
        else $error("flag driven below power-on threshold");
    chk_diag_flagmode: assert property (
        !io_supply_pin_i |=> !diag_src_en_o)
        else $error("diagnosis sources on in flag mode");
endmodule : hpd_core

// File: core/hpd_pkg.sv
// Constants, register map and types for the bridge protection block.
// Assumes a 100 MHz clock; times are held in microseconds.
package hpd_pkg;
    localparam int CLK_MHZ        = 100;
    localparam int CNT_W          = 16;
    // Chopper blanking time
    localparam int BLANK_US       = 11;
    localparam int BLANK_CYC      = BLANK_US * CLK_MHZ;
    // Least time between two chopper transitions
    localparam int TRANS_US       = 90;
    localparam int TRANS_CYC      = TRANS_US * CLK_MHZ;
    // Short filter time and peer switch-off delay
    localparam int FILT_US        = 2;
    localparam int FILT_CYC       = FILT_US * CLK_MHZ;
    localparam int DEL_US         = 1;
    localparam int DEL_CYC        = DEL_US * CLK_MHZ;
    // Longest enable/disable delay per slew rate
    localparam int DDIS_FAST_US   = 20;
    localparam int DDIS_FAST_CYC  = DDIS_FAST_US * CLK_MHZ;
    localparam int DDIS_SLOW_US   = 75;
    localparam int DDIS_SLOW_CYC  = DDIS_SLOW_US * CLK_MHZ;
    // Register map, byte addresses
    localparam int ADDR_W         = 8;
    localparam logic [7:0] REG_CTRL  = 8'h00;
    localparam logic [7:0] REG_STAT  = 8'h04;
    localparam logic [7:0] REG_FAULT = 8'h08;
    // Control fields
    localparam int CTRL_SINGLE    = 0;
    localparam int CTRL_CL_LO     = 1;
    localparam int CTRL_CL_HI     = 2;
    localparam int CTRL_SLOW      = 3;
    localparam logic [1:0] CL_RST = 2'h2;
    // Status fields
    localparam int ST_SCG         = 0;
    localparam int ST_SCB         = 2;
    localparam int ST_OT          = 4;
    localparam int ST_UV          = 5;
    localparam int ST_OL          = 6;
    localparam int ST_CHOP        = 8;
    localparam int ST_FLAG        = 10;
    localparam int ST_EN          = 11;
    localparam int ST_RED         = 12;
    typedef enum logic [2:0] {
        CHP_IDLE  = 3'b001,
        CHP_BLANK = 3'b010,
        CHP_FORCE = 3'b100
    } hpd_chop_t;
endpackage : hpd_pkg

// File: core/hpd_short_filter.sv
// Short-circuit current filter for one switch.
// Assumes the comparator input is synchronous to clk_i.
`timescale 1ns/10ps
module hpd_short_filter #(
    parameter int FILT = hpd_pkg::FILT_CYC
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic arm_i,
    input  wire logic over_i,
    output logic      hit_o
);
    import hpd_pkg::*;

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    wire              run_w  = arm_i & over_i;
    wire              done_w = (cnt_r == CNT_W'(FILT - 1));

    assign cnt_nxt = !run_w ? '0 : (done_w ? cnt_r : cnt_r + CNT_W'(1));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= '0;
            hit_o <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            hit_o <= run_w & done_w & !hit_o;
        end
    end
endmodule : hpd_short_filter

// File: testbench/hpd_load_model.sv
// Load model: winding and wiring faults as seen by the current comparators.
// Assumes gate commands from the bridge core; fault_i picks the wiring.
`timescale 1ns/10ps
module hpd_load_model (
    input  wire logic       upper_a_i,
    input  wire logic       lower_b_i,
    input  wire logic [1:0] fault_i,
    output logic            over_a_o,
    output logic            hys_a_o,
    output logic            sg_a_o,
    output logic            sb_b_o
);
    assign over_a_o = (fault_i == 2'h2) && upper_a_i;
    assign hys_a_o  = !over_a_o;
    assign sg_a_o   = fault_i[0] && upper_a_i;
    assign sb_b_o   = (fault_i == 2'h3) && lower_b_i;
endmodule : hpd_load_model

// File: testbench/test_hbridge_protection_diag.sv
// Bench for the bridge protection core: bus, enable, chopper, shorts, flags.
// Assumes one 100 MHz clock and the load model on the current comparators.
`timescale 1ns/10ps
module test_hbridge_protection_diag;
    import hpd_pkg::*;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, zero;
    logic [7:0] adr_i;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o, rd;
    logic input_one_i, input_two_i, bridge_enable_n_i, bridge_off_pin_i, io_supply_pin_i;
    logic upper_over_lim_a_i, upper_below_hys_a_i, upper_short_a_i, lower_short_b_i;
    logic temp_reduce_i, temp_shutdown_i, vs_below_off_i, vs_above_on_i, vdd_mon_fault_i;
    logic vdd_below_por_i, leg_a_low_cmp_i, leg_b_low_cmp_i;
    logic upper_switch_a_o, lower_switch_a_o, upper_switch_b_o, lower_switch_b_o;
    logic limit_reduce_o, diag_src_en_o, fault_flag_pin_o, fault_flag_pin_oe_o;
    logic [1:0] limit_sel_o, fault;
    wire [3:0] sw = {upper_switch_a_o, lower_switch_a_o, upper_switch_b_o, lower_switch_b_o};
    int n_errors = 0, checks_done = 0, cycles = 0, n;
    localparam int SLOW_CYC = 40;

    hpd_core #(.TRANS_CYC_P(16'h0032), .DDIS_SLOW_CYC_P(16'(SLOW_CYC))) i_dut (
        .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
        .input_one_i, .input_two_i, .bridge_enable_n_i, .bridge_off_pin_i, .io_supply_pin_i,
        .upper_over_lim_a_i, .upper_over_lim_b_i(zero), .upper_below_hys_a_i,
        .upper_below_hys_b_i(1'b1), .upper_short_a_i, .upper_short_b_i(zero),
        .lower_short_a_i(zero), .lower_short_b_i, .temp_reduce_i, .temp_shutdown_i,
        .vs_below_off_i, .vs_above_on_i, .vdd_mon_fault_i, .vdd_below_por_i,
        .leg_a_low_cmp_i, .leg_b_low_cmp_i, .leg_a_high_cmp_i(zero), .leg_b_high_cmp_i(zero),
        .upper_switch_a_o, .lower_switch_a_o, .upper_switch_b_o, .lower_switch_b_o,
        .limit_sel_o, .limit_reduce_o, .diag_src_en_o, .fault_flag_pin_o, .fault_flag_pin_oe_o);
    hpd_load_model i_load (.upper_a_i(upper_switch_a_o), .lower_b_i(lower_switch_b_o),
        .fault_i(fault), .over_a_o(upper_over_lim_a_i), .hys_a_o(upper_below_hys_a_i),
        .sg_a_o(upper_short_a_i), .sb_b_o(lower_short_b_i));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            n_errors++;
            test_done();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        {cyc_i, stb_i} <= 2'h3;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        @(posedge clk_i);
        while (ack_o !== 1'b1) begin
            @(posedge clk_i);
        end
        rd = dat_o;
        {cyc_i, stb_i} <= 2'h0;
        @(posedge clk_i);
    endtask : wb
    task automatic wait_sw(input logic [3:0] e, input int lim);
        n = 0;
        while (sw !== e && n < lim) begin
            @(posedge clk_i);
            n++;
        end
    endtask : wait_sw
    task automatic t_regs();
        wb(1'b0, REG_CTRL, 32'h0);
        chk("ctrl_rst", rd, 32'h4);
        wb(1'b0, 8'h0c, 32'h0);
        chk("unmapped", rd, 32'h0);
        for (int c = 0; c < 4; c++) begin
            wb(1'b1, REG_CTRL, 32'(c << 1));
            chk("limit_sel", limit_sel_o, 32'(c));
        end
        $display("t_regs end");
    endtask : t_regs
    task automatic t_enable();
        bridge_enable_n_i <= 1'b0;
        wait_sw(4'b1001, DDIS_FAST_CYC + 2);
        chk("enable", sw, 4'b1001);
        fault <= 2'h2;
        wait_sw(4'b1010, BLANK_CYC + 20);
        chk("chop_on", sw, 4'b1010);
        chk("blanking", 32'(n >= BLANK_CYC), 32'h1);
        fault <= 2'h0;
        wait_sw(4'b1001, 70);
        chk("chop_off", sw, 4'b1001);
        chk("trans_gap", 32'(n >= 40), 32'h1);
        $display("t_enable end");
    endtask : t_enable
    task automatic t_short(input logic [1:0] code, input logic [31:0] st);
        fault <= code;
        wait_sw(4'h0, FILT_CYC + DEL_CYC + 20);
        chk("short_off", sw, 4'h0);
        if (code == 2'h1) chk("peer_dly", 32'(n >= FILT_CYC + DEL_CYC), 32'h1);
        chk("diag_short", diag_src_en_o, 1'b0);
        wb(1'b0, REG_STAT, 32'h0);
        chk("stat_short", rd & 32'hf, st);
        fault <= 2'h0;
        wb(1'b1, REG_FAULT, 32'hf);
        wb(1'b0, REG_FAULT, 32'h0);
        chk("fault_clr", rd & 32'hf, 32'h0);
        wait_sw(4'b1001, DDIS_FAST_CYC + 20);
        chk("recover", sw, 4'b1001);
        $display("t_short end");
    endtask : t_short
    task automatic t_prot();
        {temp_reduce_i, temp_shutdown_i} <= 2'h3;
        wait_sw(4'h0, 5);
        chk("ot_off", sw, 4'h0);
        chk("red_sd", limit_reduce_o, 1'b0);
        temp_shutdown_i <= 1'b0;
        wait_sw(4'b1001, DDIS_FAST_CYC + 20);
        chk("ot_back", sw, 4'b1001);
        chk("reduce", limit_reduce_o, 1'b1);
        {temp_reduce_i, vs_above_on_i, vs_below_off_i} <= 3'h1;
        wait_sw(4'h0, 5);
        chk("uv_off", sw, 4'h0);
        vs_below_off_i <= 1'b0;
        repeat (20) @(posedge clk_i);
        chk("uv_hold", sw, 4'h0);
        vs_above_on_i <= 1'b1;
        wait_sw(4'b1001, DDIS_FAST_CYC + 20);
        chk("uv_back", sw, 4'b1001);
        $display("t_prot end");
    endtask : t_prot
    task automatic t_single();
        wb(1'b1, REG_CTRL, 32'h1);
        fault <= 2'h2;
        repeat (BLANK_CYC + 20) @(posedge clk_i);
        chk("no_chop", sw, 4'b1001);
        fault <= 2'h1;
        wait_sw(4'b0001, FILT_CYC + 20);
        chk("own_off", sw, 4'b0001);
        repeat (DEL_CYC + 20) @(posedge clk_i);
        chk("peer_runs", sw, 4'b0001);
        fault <= 2'h0;
        wb(1'b1, REG_FAULT, 32'hf);
        wb(1'b1, REG_CTRL, 32'h8);
        wait_sw(4'b1001, 5);
        chk("single_back", sw, 4'b1001);
        $display("t_single end");
    endtask : t_single
    task automatic t_flag();
        {bridge_enable_n_i, leg_a_low_cmp_i, leg_b_low_cmp_i} <= 3'h5;
        wait_sw(4'h0, SLOW_CYC + 2);
        chk("disable", sw, 4'h0);
        repeat (5) @(posedge clk_i);
        chk("diag_on", diag_src_en_o, 1'b1);
        wb(1'b0, REG_STAT, 32'h0);
        chk("open_load", rd[ST_OL], 1'b1);
        leg_a_low_cmp_i <= 1'b1;
        @(posedge clk_i);
        wb(1'b0, REG_STAT, 32'h0);
        chk("load_ok", rd[ST_OL], 1'b0);
        wb(1'b1, REG_CTRL, 32'h1);
        leg_b_low_cmp_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, REG_STAT, 32'h0);
        chk("ol_single", rd[ST_OL+1:ST_OL], 2'h2);
        io_supply_pin_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        chk("flag_low", {fault_flag_pin_oe_o, fault_flag_pin_o}, 2'h2);
        chk("diag_flag", diag_src_en_o, 1'b0);
        vdd_below_por_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        chk("flag_por", fault_flag_pin_oe_o, 1'b0);
        $display("t_flag end");
    endtask : t_flag
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done
    initial begin
        {cyc_i, stb_i, we_i, input_two_i, bridge_off_pin_i, zero, fault} = '0;
        {temp_reduce_i, temp_shutdown_i, vs_below_off_i, vdd_mon_fault_i} = '0;
        {vdd_below_por_i, leg_a_low_cmp_i, leg_b_low_cmp_i, adr_i, dat_i} = '0;
        {rst_i, input_one_i, bridge_enable_n_i, io_supply_pin_i, vs_above_on_i} = '1;
        sel_i = 4'hf;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_regs();
        t_enable();
        t_short(2'h1, 32'h1);
        t_short(2'h3, 32'h9);
        t_prot();
        t_single();
        t_flag();
        test_done();
    end
endmodule : test_hbridge_protection_diag
